// ===== src/cab_exec_unit.sv
// Arithmetic, compare, skip and branch execution unit with port F input register
`timescale 1ns/1ps
module cab_exec_unit
	import cab_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_reset_n,
	input  wire logic        i_issue_valid,
	input  wire cab_issue_t  i_issue,
	input  wire logic        i_flags_load,
	input  wire logic [7:0]  i_flags_value,
	input  wire logic [7:0]  i_port_f_pins,
	output logic             o_issue_ready,
	output logic             o_done,
	output cab_result_t      o_result,
	output logic      [7:0]  o_flags,
	output logic      [7:0]  o_port_f_levels
);
	typedef enum logic {st_idle, st_hold} cab_state_t;

	cab_state_t  state_ff;
	logic [1:0]  cnt_ff;
	logic        done_ff;
	cab_result_t res_ff;
	cab_result_t pend_ff;
	logic [7:0]  pend_flags_ff;
	logic        pend_mult_ff;
	logic [7:0]  flags_ff;
	logic [7:0]  pf_sync1_ff;
	logic [7:0]  pf_sync2_ff;

	cab_result_t nxt_res;
	logic [7:0]  nxt_flags;
	logic [1:0]  nxt_cyc;
	logic        accept;
	logic        finish_hold;
	logic        is_mult;
	logic        m_frac;
	logic        m_as;
	logic        m_bs;
	logic [7:0]  io_val;
	logic [7:0]  bit_mask;
	logic [15:0] tgt;
	logic [15:0] seq_pc;
	logic [15:0] skip_pc;
	logic [1:0]  skip_cyc;
	logic        a_sub;
	logic        a_cin;
	logic [7:0]  a_b;
	logic [7:0]  a_sum;
	logic        a_c;
	logic        a_h;
	logic        a_v;
	logic        w_sub;
	logic [15:0] w_sum;
	logic        w_c;
	logic        w_v;
	logic [15:0] m_prod;
	logic        m_z;
	logic        m_c;

	assign accept = i_issue_valid && (state_ff == st_idle);
	assign finish_hold = (state_ff == st_hold) && (cnt_ff == CYC_1);
	assign o_issue_ready = (state_ff == st_idle);

	// Port F pins: two flops before anything reads them
	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			pf_sync1_ff <= PORT_F_RST;
			pf_sync2_ff <= PORT_F_RST;
		end
		else
		begin
			pf_sync1_ff <= i_port_f_pins;
			pf_sync2_ff <= pf_sync1_ff;
		end
	end

	// Operand selection for the byte adder
	always_comb
	begin
		a_sub = 1'b1;
		a_cin = 1'b0;
		a_b = i_issue.rr;
		case (i_issue.op)
			op_sum_registers: a_sub = 1'b0; // RULE1
			op_sum_with_carry:
			begin
				a_sub = 1'b0;
				a_cin = flags_ff[FLG_C]; // RULE1
			end
			op_minus_constant, op_compare_immediate: a_b = i_issue.k; // RULE2
			op_minus_with_borrow, op_compare_with_borrow: a_cin = flags_ff[FLG_C];
			op_minus_constant_with_borrow:
			begin
				a_b = i_issue.k;
				a_cin = flags_ff[FLG_C]; // RULE2
			end
			default: a_sub = 1'b1;
		endcase
	end

	assign w_sub = (i_issue.op == op_pair_minus_immediate);

	cab_addsub #(.W(8)) u_byte_addsub (
		.i_a     (i_issue.rd),
		.i_b     (a_b),
		.i_cin   (a_cin),
		.i_sub   (a_sub),
		.o_sum   (a_sum),
		.o_carry (a_c),
		.o_half  (a_h),
		.o_ovf   (a_v)
	);

	// Word immediate is six bits, zero-extended
	cab_addsub #(.W(16)) u_word_addsub (
		.i_a     (i_issue.pair),
		.i_b     ({10'h000, i_issue.k[5:0]}),
		.i_cin   (1'b0),
		.i_sub   (w_sub),
		.o_sum   (w_sum),
		.o_carry (w_c),
		.o_half  (),
		.o_ovf   (w_v)
	);

	cab_multiplier u_mult (
		.i_mclk     (i_mclk),
		.i_reset_n  (i_reset_n),
		.i_go       (accept && is_mult),
		.i_a        (i_issue.rd),
		.i_b        (i_issue.rr),
		.i_a_signed (m_as),
		.i_b_signed (m_bs),
		.i_frac     (m_frac),
		.o_prod     (m_prod),
		.o_zero     (m_z),
		.o_carry    (m_c)
	);

	// Product kinds
	always_comb
	begin
		is_mult = 1'b1;
		m_as = 1'b0;
		m_bs = 1'b0;
		m_frac = 1'b0;
		case (i_issue.op)
			op_unsigned_product: m_as = 1'b0;
			op_signed_product: {m_as, m_bs} = 2'h3;
			op_mixed_sign_product: m_as = 1'b1;
			op_fraction_unsigned_product: m_frac = 1'b1;
			op_fraction_signed_product: {m_as, m_bs, m_frac} = 3'h7;
			op_fraction_mixed_product: {m_as, m_frac} = 2'h3;
			default: is_mult = 1'b0;
		endcase
	end

	// Port F reads locally; other I/O comes from the fetch path
	assign io_val = (i_issue.io_addr == IO_PORT_F_OFS) ? pf_sync2_ff : i_issue.io_data;
	assign bit_mask = 8'h01 << i_issue.k[2:0];
	assign tgt = i_issue.pc + {{9{i_issue.offs[6]}}, i_issue.offs} + PC_STEP;
	assign seq_pc = i_issue.pc + PC_STEP;
	assign skip_pc = i_issue.pc + (i_issue.next_long ? PC_SKIP_L : PC_SKIP_S);
	assign skip_cyc = i_issue.next_long ? CYC_3 : CYC_2;

	// Decode: results, flags and cycle count; untouched flags keep value
	always_comb
	begin
		logic br;
		logic sk;
		logic lg;
		logic [7:0] lr;
		br = 1'b0;
		sk = 1'b0;
		lg = 1'b0;
		lr = 8'h00;
		nxt_res = '0;
		nxt_flags = flags_ff; // RULE23
		nxt_cyc = CYC_1;
		nxt_res.pc_we = 1'b1;
		nxt_res.pc = seq_pc; // RULE23
		case (i_issue.op)
			op_sum_registers, op_sum_with_carry, op_minus_registers, op_minus_constant,
			op_minus_with_borrow, op_minus_constant_with_borrow,
			op_compare_registers, op_compare_with_borrow, op_compare_immediate:
			begin
				// Compares drop the difference
				nxt_res.rd_we = (i_issue.op != op_compare_registers) &&
					(i_issue.op != op_compare_with_borrow) &&
					(i_issue.op != op_compare_immediate); // RULE12
				nxt_res.rd_data = a_sum;
				nxt_flags[FLG_C] = a_c; // RULE1 RULE2 RULE12
				nxt_flags[FLG_H] = a_h;
				nxt_flags[FLG_N] = a_sum[7];
				nxt_flags[FLG_V] = a_v;
				nxt_flags[FLG_Z] = (a_sum == 8'h00);
				// Borrow chains keep Z only if it was already set
				if (a_sub && a_cin == flags_ff[FLG_C] && i_issue.op != op_minus_registers &&
					i_issue.op != op_minus_constant && i_issue.op != op_compare_registers &&
					i_issue.op != op_compare_immediate)
					nxt_flags[FLG_Z] = (a_sum == 8'h00) && flags_ff[FLG_Z];
			end
			op_add_immediate_word, op_pair_minus_immediate:
			begin
				nxt_cyc = CYC_2; // RULE3
				nxt_res.pair_we = 1'b1;
				nxt_res.pair_data = w_sum;
				nxt_flags[FLG_C] = w_c;
				nxt_flags[FLG_Z] = (w_sum == 16'h0000);
				nxt_flags[FLG_N] = w_sum[15];
				nxt_flags[FLG_V] = w_v;
				nxt_flags[FLG_S] = w_sum[15] ^ w_v; // RULE3
			end
			op_bitwise_conjunction: {lg, lr} = {1'b1, i_issue.rd & i_issue.rr}; // RULE4
			op_conj_immediate: {lg, lr} = {1'b1, i_issue.rd & i_issue.k};
			op_bitwise_disjunction: {lg, lr} = {1'b1, i_issue.rd | i_issue.rr};
			op_disj_immediate: {lg, lr} = {1'b1, i_issue.rd | i_issue.k};
			op_bitwise_exclusive_disjunction: {lg, lr} = {1'b1, i_issue.rd ^ i_issue.rr};
			op_set_bits_mask: {lg, lr} = {1'b1, i_issue.rd | i_issue.k}; // RULE5
			op_clear_bits_mask: {lg, lr} = {1'b1, i_issue.rd & (BYTE_ALL - i_issue.k)}; // RULE5
			op_zero_sign_test: lr = i_issue.rd & i_issue.rd; // RULE6
			op_unsigned_product, op_signed_product, op_mixed_sign_product,
			op_fraction_unsigned_product, op_fraction_signed_product, op_fraction_mixed_product:
			begin
				nxt_cyc = CYC_2; // RULE7 RULE8
				nxt_res.pair_we = 1'b1;
				nxt_res.pair_r1r0 = 1'b1;
			end
			op_jump_via_pointer:
			begin
				nxt_cyc = CYC_2; // RULE9
				nxt_res.pc = i_issue.ptr;
			end
			op_call_via_pointer:
			begin
				nxt_cyc = CYC_3; // RULE10
				nxt_res.pc = i_issue.ptr;
				nxt_res.push_we = 1'b1;
				nxt_res.push = seq_pc;
			end
			op_skip_on_equal: sk = (i_issue.rd == i_issue.rr); // RULE11
			op_skip_reg_bit_low: sk = !i_issue.rr[i_issue.k[2:0]]; // RULE13
			op_skip_reg_bit_high: sk = i_issue.rr[i_issue.k[2:0]];
			op_skip_io_bit_low: sk = !io_val[i_issue.k[2:0]]; // RULE14
			op_skip_io_bit_high: sk = io_val[i_issue.k[2:0]];
			op_branch_status_bit_set: br = flags_ff[i_issue.k[2:0]]; // RULE15
			op_branch_status_bit_clear: br = !flags_ff[i_issue.k[2:0]];
			op_branch_carry_set: br = flags_ff[FLG_C]; // RULE16
			op_branch_carry_clear: br = !flags_ff[FLG_C];
			op_branch_signed_ge: br = !(flags_ff[FLG_N] ^ flags_ff[FLG_V]); // RULE17
			op_branch_signed_lt: br = flags_ff[FLG_N] ^ flags_ff[FLG_V];
			op_branch_half_carry_set: br = flags_ff[FLG_H]; // RULE18
			op_branch_half_carry_clear: br = !flags_ff[FLG_H];
			op_branch_transfer_flag_set: br = flags_ff[FLG_T]; // RULE19
			op_branch_transfer_flag_clear: br = !flags_ff[FLG_T];
			op_branch_overflow_set: br = flags_ff[FLG_V]; // RULE20
			op_branch_overflow_clear: br = !flags_ff[FLG_V];
			op_set_io_bit, op_clear_io_bit:
			begin
				// Whole register written back: flags read as one get cleared
				nxt_res.io_we = (i_issue.io_addr <= IO_BITOP_MAX) &&
					(i_issue.io_addr != IO_PORT_F_OFS); // RULE22
				nxt_res.io_addr = i_issue.io_addr;
				nxt_res.io_data = (i_issue.op == op_set_io_bit) ?
					(io_val | bit_mask) : (io_val & ~bit_mask); // RULE21
			end
			default: nxt_res.pc_we = 1'b0;
		endcase
		if (lg)
			nxt_res.rd_we = 1'b1;
		if (lg || i_issue.op == op_zero_sign_test)
		begin
			nxt_res.rd_data = lr;
			nxt_flags[FLG_Z] = (lr == 8'h00); // RULE4 RULE6
			nxt_flags[FLG_N] = lr[7];
			nxt_flags[FLG_V] = 1'b0;
		end
		if (br)
		begin
			nxt_cyc = CYC_2; // RULE15
			nxt_res.pc = tgt;
		end
		if (sk)
		begin
			nxt_cyc = skip_cyc; // RULE11 RULE13 RULE14
			nxt_res.pc = skip_pc;
		end
	end

	// Sequencer: multi-cycle ops wait in hold
	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_ff <= st_idle;
			cnt_ff <= 2'h0;
		end
		else
		begin
			case (state_ff)
				st_idle:
					if (accept && nxt_cyc != CYC_1)
					begin
						state_ff <= st_hold;
						cnt_ff <= nxt_cyc - CYC_1;
					end
				st_hold:
				begin
					cnt_ff <= cnt_ff - CYC_1;
					if (cnt_ff == CYC_1)
						state_ff <= st_idle;
				end
				default: state_ff <= st_idle;
			endcase
		end
	end

	// Pending results for multi-cycle ops
	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			pend_ff <= '0;
			pend_flags_ff <= FLAGS_RST;
			pend_mult_ff <= 1'b0;
		end
		else if (accept)
		begin
			pend_ff <= nxt_res;
			pend_flags_ff <= nxt_flags;
			pend_mult_ff <= is_mult;
		end
	end

	// Outputs: strobes stand one cycle; execution beats a flags load
	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			res_ff <= '0;
			done_ff <= 1'b0;
			flags_ff <= FLAGS_RST;
		end
		else
		begin
			res_ff <= '0;
			done_ff <= 1'b0;
			if (accept && nxt_cyc == CYC_1)
			begin
				res_ff <= nxt_res;
				done_ff <= 1'b1;
				flags_ff <= nxt_flags;
			end
			else if (finish_hold)
			begin
				res_ff <= pend_ff;
				done_ff <= 1'b1;
				flags_ff <= pend_flags_ff;
				if (pend_mult_ff)
				begin
					res_ff.pair_data <= m_prod; // RULE7 RULE8
					flags_ff[FLG_Z] <= m_z;
					flags_ff[FLG_C] <= m_c;
				end
			end
			else if (i_flags_load)
				flags_ff <= i_flags_value;
		end
	end

	assign o_done = done_ff;
	assign o_result = res_ff;
	assign o_flags = flags_ff;
	assign o_port_f_levels = pf_sync2_ff;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	sequence two_cyc_s;
		!o_done ##1 o_done;
	endsequence

	add_result_a: assert property (accept && i_issue.op == op_sum_registers |=> // RULE1
		o_done && o_result.rd_we && o_result.rd_data == $past(i_issue.rd + i_issue.rr))
		else $error("sum wrong or late");
	sub_borrow_a: assert property (accept && i_issue.op == op_minus_constant |=> // RULE2
		o_flags[FLG_C] == ($past(i_issue.rd) < $past(i_issue.k)))
		else $error("subtract borrow wrong");
	word_add_a: assert property (accept && i_issue.op == op_add_immediate_word |=> // RULE3
		two_cyc_s ##0 o_result.pair_data == $past(i_issue.pair + {10'h000, i_issue.k[5:0]}, 2))
		else $error("word add wrong");
	logic_flags_a: assert property (accept && i_issue.op == op_bitwise_exclusive_disjunction |=> // RULE4
		!o_flags[FLG_V] && o_flags[FLG_C] == $past(flags_ff[FLG_C]))
		else $error("logic flags wrong");
	mask_clear_a: assert property (accept && i_issue.op == op_clear_bits_mask |=> // RULE5
		o_result.rd_data == ($past(i_issue.rd) & ~$past(i_issue.k)))
		else $error("mask clear wrong");
	test_zero_a: assert property (accept && i_issue.op == op_zero_sign_test |=> // RULE6
		!o_result.rd_we && o_flags[FLG_Z] == ($past(i_issue.rd) == 8'h00))
		else $error("test flags wrong");
	mult_pair_a: assert property (accept && i_issue.op == op_unsigned_product |=> // RULE7
		two_cyc_s ##0 o_result.pair_r1r0 && o_result.pair_data == $past({8'h00, i_issue.rd} * i_issue.rr, 2))
		else $error("product wrong");
	ptr_jump_a: assert property (accept && i_issue.op == op_jump_via_pointer |=> // RULE9
		two_cyc_s ##0 o_result.pc == $past(i_issue.ptr, 2) && $stable(o_flags))
		else $error("pointer jump wrong");
	ptr_call_a: assert property (accept && i_issue.op == op_call_via_pointer |=> // RULE10
		!o_done [*2] ##1 o_done && o_result.push_we)
		else $error("pointer call wrong");
	cmp_nostore_a: assert property (accept && i_issue.op == op_compare_registers |=> // RULE12
		o_done && !o_result.rd_we)
		else $error("compare stored result");
	branch_taken_a: assert property (accept && i_issue.op == op_branch_carry_set && flags_ff[FLG_C] |=> // RULE16
		two_cyc_s ##0 o_result.pc == $past(tgt, 2))
		else $error("branch target wrong");
	io_range_a: assert property (o_result.io_we |-> o_result.io_addr <= IO_BITOP_MAX) // RULE22
		else $error("I/O bit op out of range");
endmodule : cab_exec_unit

// ===== src/cab_pkg.sv
// Package: opcodes, flag positions, timing counts and carriers for the exec unit
// Behaviour
// RULE1 - Add registers, optionally with carry; ZCNVH; 1 cycle
// RULE2 - Subtract register or constant, optional borrow; ZCNVH
// RULE3 - Word add/subtract immediate on pair; ZCNVS; 2 cycles
// RULE4 - AND/OR/XOR and immediates; ZNV only; 1 cycle
// RULE5 - Mask set ORs, mask clear ANDs 0xFF-mask
// RULE6 - Zero/sign test keeps value, sets ZNV
// RULE7 - Products into pair one-zero; ZC; 2 cycles
// RULE8 - Fractional products shift left one; ZC; 2 cycles
// RULE9 - Pointer jump loads PC, flags kept, 2 cycles
// RULE10 - Pointer call pushes return, loads PC, 3 cycles
// RULE11 - Equal registers skip next instruction, 1/2/3 cycles
// RULE12 - Compares subtract without storing; ZNVCH; 1 cycle
// RULE13 - Register bit low/high skips next instruction
// RULE14 - I/O bit low/high skips next instruction
// RULE15 - Flags bit branch to PC+offset+1; 1/2 cycles
// RULE16 - Carry branches, same-or-higher/lower aliases; 1/2 cycles
// RULE17 - Signed branches on N xor V
// RULE18 - Half-carry branches, 1 untaken, 2 taken
// RULE19 - Transfer flag branches to PC+offset+1
// RULE20 - Overflow branches, flags unchanged, 1/2 cycles
// RULE21 - I/O bit ops rewrite whole register, clearing set flags
// RULE22 - I/O bit ops reach addresses 0x00 to 0x1F only; the unit writes back 0x01 to 0x1F, never port F at 0x00
// RULE23 - Unlisted flags kept; untaken goes to next instruction
package cab_pkg;

	// Flag positions in the flags register
	localparam int unsigned FLG_C = 0;
	localparam int unsigned FLG_Z = 1;
	localparam int unsigned FLG_N = 2;
	localparam int unsigned FLG_V = 3;
	localparam int unsigned FLG_S = 4;
	localparam int unsigned FLG_H = 5;
	localparam int unsigned FLG_T = 6;
	localparam logic [7:0] FLAGS_RST = 8'h00;

	// I/O space
	localparam logic [5:0] IO_PORT_F_OFS = 6'h00;
	localparam logic [5:0] IO_BITOP_MAX  = 6'h1F;
	localparam logic [7:0] BYTE_ALL      = 8'hFF;
	localparam logic [7:0] PORT_F_RST    = 8'h00;

	// Cycle counts and PC steps
	localparam logic [1:0]  CYC_1     = 2'h1;
	localparam logic [1:0]  CYC_2     = 2'h2;
	localparam logic [1:0]  CYC_3     = 2'h3;
	localparam logic [15:0] PC_STEP   = 16'h0001;
	localparam logic [15:0] PC_SKIP_S = 16'h0002;
	localparam logic [15:0] PC_SKIP_L = 16'h0003;

	typedef enum logic [5:0] {
		op_idle,
		op_sum_registers, op_sum_with_carry,
		op_minus_registers, op_minus_constant,
		op_minus_with_borrow, op_minus_constant_with_borrow,
		op_add_immediate_word, op_pair_minus_immediate,
		op_bitwise_conjunction, op_conj_immediate,
		op_bitwise_disjunction, op_disj_immediate,
		op_bitwise_exclusive_disjunction,
		op_set_bits_mask, op_clear_bits_mask, op_zero_sign_test,
		op_unsigned_product, op_signed_product, op_mixed_sign_product,
		op_fraction_unsigned_product, op_fraction_signed_product,
		op_fraction_mixed_product,
		op_jump_via_pointer, op_call_via_pointer, op_skip_on_equal,
		op_compare_registers, op_compare_with_borrow, op_compare_immediate,
		op_skip_reg_bit_low, op_skip_reg_bit_high,
		op_skip_io_bit_low, op_skip_io_bit_high,
		op_branch_status_bit_set, op_branch_status_bit_clear,
		op_branch_carry_set, op_branch_carry_clear,
		op_branch_signed_ge, op_branch_signed_lt,
		op_branch_half_carry_set, op_branch_half_carry_clear,
		op_branch_transfer_flag_set, op_branch_transfer_flag_clear,
		op_branch_overflow_set, op_branch_overflow_clear,
		op_set_io_bit, op_clear_io_bit
	} cab_op_t;

	// Decoded instruction from the fetch path
	typedef struct packed {
		cab_op_t     op;
		logic [7:0]  rd;
		logic [7:0]  rr;
		logic [7:0]  k;
		logic [15:0] pair;
		logic [15:0] ptr;
		logic [15:0] pc;
		logic [6:0]  offs;
		logic [5:0]  io_addr;
		logic [7:0]  io_data;
		logic        next_long;
	} cab_issue_t;

	// Write-back strobes and data
	typedef struct packed {
		logic        rd_we;
		logic [7:0]  rd_data;
		logic        pair_we;
		logic        pair_r1r0;
		logic [15:0] pair_data;
		logic        pc_we;
		logic [15:0] pc;
		logic        push_we;
		logic [15:0] push;
		logic        io_we;
		logic [5:0]  io_addr;
		logic [7:0]  io_data;
	} cab_result_t;

endpackage : cab_pkg

// ===== src/cab_addsub.sv
// Add/subtract stage with carry, half-carry and overflow
`timescale 1ns/1ps
module cab_addsub #(
	parameter int unsigned W = 8
) (
	input  wire logic [W-1:0] i_a,
	input  wire logic [W-1:0] i_b,
	input  wire logic         i_cin,
	input  wire logic         i_sub,
	output logic      [W-1:0] o_sum,
	output logic              o_carry,
	output logic              o_half,
	output logic              o_ovf
);
	logic [W-1:0] b_eff;
	logic         c_eff;
	logic [W:0]   full;
	logic [4:0]   nib;

	// Subtract as a + ~b + ~borrow so one adder serves both
	assign b_eff = i_sub ? ~i_b : i_b;
	assign c_eff = i_sub ? ~i_cin : i_cin;
	assign full = {1'b0, i_a} + {1'b0, b_eff} + {{W{1'b0}}, c_eff};
	assign nib = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
	// Carry outs inverted on subtract to read as borrow
	assign o_sum = full[W-1:0];
	assign o_carry = full[W] ^ i_sub;
	assign o_half = nib[4] ^ i_sub;
	assign o_ovf = (i_a[W-1] == b_eff[W-1]) && (o_sum[W-1] != i_a[W-1]);
endmodule : cab_addsub

// ===== src/cab_multiplier.sv
// One-stage 8x8 multiplier, signed/unsigned/mixed, optional fraction shift
`timescale 1ns/1ps
module cab_multiplier (
	input  wire logic        i_mclk,
	input  wire logic        i_reset_n,
	input  wire logic        i_go,
	input  wire logic [7:0]  i_a,
	input  wire logic [7:0]  i_b,
	input  wire logic        i_a_signed,
	input  wire logic        i_b_signed,
	input  wire logic        i_frac,
	output logic      [15:0] o_prod,
	output logic             o_zero,
	output logic             o_carry
);
	logic signed [17:0] full;
	logic        [15:0] nxt_prod;
	logic        [15:0] prod_ff;
	logic               zero_ff;
	logic               carry_ff;

	// Ninth bit makes one signed multiply cover all three sign mixes
	assign full = $signed({i_a_signed & i_a[7], i_a}) * $signed({i_b_signed & i_b[7], i_b});
	assign nxt_prod = i_frac ? {full[14:0], 1'b0} : full[15:0]; // RULE8

	// Product captured at issue, read by the unit one cycle later
	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			prod_ff <= 16'h0000;
			zero_ff <= 1'b0;
			carry_ff <= 1'b0;
		end
		else if (i_go)
		begin
			prod_ff <= nxt_prod; // RULE7
			zero_ff <= (nxt_prod == 16'h0000);
			carry_ff <= full[15]; // Carry is the unshifted top bit
		end
	end

	assign o_prod = prod_ff;
	assign o_zero = zero_ff;
	assign o_carry = carry_ff;
endmodule : cab_multiplier

// ===== testbench/cab_io_model.sv
// I/O register space model on the far side of the exec unit bit operations
`timescale 1ns/1ps
module cab_io_model (
	input  wire logic       i_mclk,
	input  wire logic       i_reset_n,
	input  wire logic [5:0] i_addr,
	input  wire logic       i_we,
	input  wire logic [5:0] i_waddr,
	input  wire logic [7:0] i_wdata,
	output logic      [7:0] o_rdata
);
	logic [7:0] regs_ff [0:31];
	// Read is immediate, since io_data is sampled with the issue
	assign o_rdata = regs_ff[i_addr[4:0]];
	// Status at 0x0E clears bits written as one; nothing exists above 0x1F
	always_ff @(posedge i_mclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			for (int i = 0; i < 32; i++)
				regs_ff[i] <= 8'hC3 ^ 8'(i);
		end
		else if (i_we && i_waddr <= 6'h1F)
			regs_ff[i_waddr[4:0]] <= (i_waddr == 6'h0E) ? (regs_ff[14] & ~i_wdata) : i_wdata;
	end
endmodule : cab_io_model

// ===== testbench/cab_exec_unit_tb.sv
// Self-checking bench: exec unit against an integer reference model
`timescale 1ns/1ps
module cab_exec_unit_tb
	import cab_pkg::*;
;
	logic        i_mclk, i_reset_n, iv, fl, rdy, done;
	logic [7:0]  fv, pins, io_rd, flg, pf, mf, rb;
	logic [15:0] lf;
	cab_issue_t  iss, iss_w;
	cab_result_t res;
	int          fail_count, check_count;

	cab_exec_unit uut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_issue_valid(iv), .i_issue(iss_w),
		.i_flags_load(fl), .i_flags_value(fv), .i_port_f_pins(pins), .o_issue_ready(rdy), .o_done(done),
		.o_result(res), .o_flags(flg), .o_port_f_levels(pf));
	cab_io_model io (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(iss.io_addr), .i_we(res.io_we),
		.i_waddr(res.io_addr), .i_wdata(res.io_data), .o_rdata(io_rd));

	// Current I/O value rides along with the issue
	always_comb
	begin
		iss_w = iss;
		iss_w.io_data = io_rd;
	end

	// 50 MHz clock
	initial
	begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end

	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
		begin
			check_count++;
			if (s !== e)
			begin
				fail_count++;
				$display("[ERR] %s expected %h seen %h", nm, e, s);
			end
		end
	endtask : chk

	task automatic finish_test;
		begin
			$display("checks %0d errors %0d", check_count, fail_count);
			if (fail_count == 0 && check_count > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask : finish_test

	task automatic load(logic [7:0] v);
		begin
			@(posedge i_mclk);
			fl <= 1'b1;
			fv <= v;
			@(posedge i_mclk);
			fl <= 1'b0;
			mf = v;
		end
	endtask : load

	// Issue one op, model it, wait for done, compare all
	task automatic run(cab_op_t op, logic [7:0] a, logic [7:0] b, logic [6:0] of, logic nl, logic [5:0] ia);
		int n, r, c, m, sa, sb, cy;
		logic [15:0] ep, p, w, ed;
		logic [7:0] ef, x;
		logic [4:0] es;
		logic t;
		begin
			@(posedge i_mclk);
			iss <= '{op: op, rd: a, rr: (op inside {op_skip_reg_bit_low, op_skip_reg_bit_high}) ? a : b, k: b,
				pair: {a, b}, ptr: {b, a}, pc: {8'h01, a}, offs: of, io_addr: ia, io_data: 8'h00, next_long: nl};
			iv <= 1'b1;
			@(posedge i_mclk);
			iv <= 1'b0;
			#1;
			ef = mf;
			ed = 16'h0000;
			es = 5'b00100;
			ep = {8'h01, a} + 16'h0001;
			cy = 1;
			t = 1'b0;
			r = 0;
			m = (op inside {[op_sum_registers:op_minus_constant_with_borrow], [op_bitwise_conjunction:op_clear_bits_mask]})
				? 2 : int'(op inside {[op_compare_registers:op_compare_immediate], op_zero_sign_test});
			case (op) inside
				op_sum_registers, op_sum_with_carry:
				begin
					c = (op == op_sum_with_carry) ? int'(mf[FLG_C]) : 0;
					r = a + b + c;
					ef[FLG_H] = (a % 16 + b % 16 + c) > 15;
					ef[FLG_V] = (a[7] == b[7]) && (r[7] != a[7]);
					ef[FLG_C] = r > 255;
				end
				[op_minus_registers:op_minus_constant_with_borrow], [op_compare_registers:op_compare_immediate]:
				begin
					t = op inside {op_minus_with_borrow, op_minus_constant_with_borrow, op_compare_with_borrow};
					c = t ? int'(mf[FLG_C]) : 0;
					r = a - b - c;
					ef[FLG_H] = (a % 16) < (b % 16 + c);
					ef[FLG_V] = (a[7] != b[7]) && (r[7] != a[7]);
					ef[FLG_C] = a < b + c;
				end
				op_bitwise_conjunction, op_conj_immediate: r = a & b;
				op_bitwise_disjunction, op_disj_immediate, op_set_bits_mask: r = a | b;
				op_bitwise_exclusive_disjunction: r = a ^ b;
				op_clear_bits_mask: r = a & (BYTE_ALL - b);
				op_zero_sign_test: r = a;
				[op_unsigned_product:op_fraction_mixed_product]:
				begin
					sa = (op inside {op_signed_product, op_mixed_sign_product, op_fraction_signed_product,
						op_fraction_mixed_product}) ? int'($signed(a)) : int'(a);
					sb = (op inside {op_signed_product, op_fraction_signed_product}) ? int'($signed(b)) : int'(b);
					p = 16'(sa * sb);
					w = (op >= op_fraction_unsigned_product) ? p << 1 : p;
					ef[FLG_C] = p[15];
					ef[FLG_Z] = w == 16'h0000;
					es[3] = 1'b1;
					ed = w;
					cy = 2;
				end
				op_add_immediate_word, op_pair_minus_immediate:
				begin
					p = {a, b};
					w = (op == op_add_immediate_word) ? p + b[5:0] : p - b[5:0];
					ef[FLG_C] = (op == op_add_immediate_word) ? w < p : b[5:0] > p;
					ef[FLG_V] = (op == op_add_immediate_word) ? !p[15] && w[15] : p[15] && !w[15];
					ef[FLG_N] = w[15];
					ef[FLG_Z] = w == 16'h0000;
					ef[FLG_S] = w[15] ^ ef[FLG_V];
					es[3] = 1'b1;
					ed = w;
					cy = 2;
				end
				[op_branch_status_bit_set:op_branch_overflow_clear]:
				begin
					case (op) inside
						op_branch_status_bit_set, op_branch_status_bit_clear: t = mf[b[2:0]];
						op_branch_carry_set, op_branch_carry_clear: t = mf[FLG_C];
						op_branch_signed_ge, op_branch_signed_lt: t = mf[FLG_N] ^ mf[FLG_V];
						op_branch_half_carry_set, op_branch_half_carry_clear: t = mf[FLG_H];
						op_branch_transfer_flag_set, op_branch_transfer_flag_clear: t = mf[FLG_T];
						default: t = mf[FLG_V];
					endcase
					t = t ^ ((op - op_branch_status_bit_set) % 2 == 1) ^ (op inside {op_branch_signed_ge, op_branch_signed_lt});
					if (t)
					begin
						ep = ep + {{9{of[6]}}, of};
						cy = 2;
					end
					t = 1'b0;
				end
				op_skip_on_equal, [op_skip_reg_bit_low:op_skip_io_bit_high]:
				begin
					x = (op >= op_skip_io_bit_low) ? io_rd : a;
					t = (op == op_skip_on_equal) ? a == b : x[b[2:0]] ^ (op inside {op_skip_reg_bit_low, op_skip_io_bit_low});
					if (t)
					begin
						ep = ep + 16'h0001 + 16'(nl);
						cy = 2 + int'(nl);
					end
					t = 1'b0;
				end
				op_jump_via_pointer:
				begin
					ep = {b, a};
					cy = 2;
				end
				op_call_via_pointer:
				begin
					ep = {b, a};
					cy = 3;
					es[1] = 1'b1;
					ed = {8'h01, a} + 16'h0001;
				end
				op_set_io_bit, op_clear_io_bit:
				begin
					ed = 16'((op == op_set_io_bit) ? io_rd | (8'h01 << b[2:0]) : io_rd & ~(8'h01 << b[2:0]));
					es[0] = (ia != IO_PORT_F_OFS) && (ia <= IO_BITOP_MAX);
				end
				default: ;
			endcase
			if (op inside {[op_bitwise_conjunction:op_zero_sign_test]})
				ef[FLG_V] = 1'b0;
			// Byte results set Z and N; borrow chains only keep a set Z
			if (m > 0)
			begin
				ef[FLG_Z] = (r[7:0] == 8'h00) && (!t || mf[FLG_Z]);
				ef[FLG_N] = r[7];
				es[4] = (m == 2);
				ed = 16'(r[7:0]);
			end
			n = 0;
			while (done !== 1'b1 && n < 8)
			begin
				n++;
				@(posedge i_mclk);
				#1;
			end
			chk("cycles", 16'(cy), 16'(n + 1));
			chk("strobes", 16'(es), 16'({res.rd_we, res.pair_we, res.pc_we, res.push_we, res.io_we}));
			chk("pc", ep, res.pc);
			if (es[4])
				chk("rd", ed, 16'(res.rd_data));
			if (es[3])
				chk("pair", {ed[15:1], op >= op_unsigned_product}, {res.pair_data[15:1], res.pair_r1r0});
			if (es[3])
				chk("pair_lsb", 16'(ed[0]), 16'(res.pair_data[0]));
			if (es[1])
				chk("push", ed, res.push);
			if (es[0])
				chk("io", 16'({ia, ed[7:0]}), 16'({res.io_addr, res.io_data}));
			chk("flags", 16'(ef), 16'(flg));
			mf = ef;
		end
	endtask : run

	// Watchdog past the expected run length
	initial
	begin
		repeat (20000) @(posedge i_mclk);
		fail_count++;
		finish_test();
	end

	initial
	begin
		i_reset_n = 1'b0;
		{iv, fl, fv, pins, iss, mf} = '0;
		lf = 16'h4638;
		fail_count = 0;
		check_count = 0;
		repeat (4) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		#1;
		chk("reset", {FLAGS_RST, PORT_F_RST}, {flg, pf});
		chk("ready", 16'h0001, 16'(rdy));
		// Every op per round, random data and flags; odd rounds use equal operands
		for (int rnd = 0; rnd < 8; rnd++)
		begin
			lf = lfsr(lf);
			load(lf[7:0] & 8'h7F);
			pins <= lf[15:8];
			for (int o = 1; o <= op_clear_io_bit; o++)
			begin
				lf = lfsr(lf);
				rb = lf[7:0];
				lf = lfsr(lf);
				run(cab_op_t'(o), rb, rnd[0] ? rb : lf[7:0], lf[14:8], lf[15], 6'(lf[4:0] | 5'h01));
			end
			chk("port_f", 16'(pins), 16'(pf));
		end
		run(op_sum_registers, 8'hFF, 8'h01, 7'h00, 1'b0, 6'h01);
		run(op_set_io_bit, 8'h00, 8'h02, 7'h00, 1'b0, IO_PORT_F_OFS);
		run(op_clear_io_bit, 8'h00, 8'h03, 7'h00, 1'b0, 6'h25);
		run(op_set_io_bit, 8'h00, 8'h04, 7'h00, 1'b0, 6'h0E);
		run(op_skip_io_bit_high, 8'h00, 8'h07, 7'h7F, 1'b1, 6'h0E);
		finish_test();
	end
endmodule : cab_exec_unit_tb
